// ==== mode_supply_control_regs.sv ====
// Mode/supply and hardware-config control registers with the
// serial frame port that reaches them.
// Assumes the mode state machine, watchdog, regulators and status
// registers live outside and meet this block through plain ports.
//
// Notes on behaviour
// - Mode bits 7:6: 00 normal, 01 sleep, 10 stop, 11 soft reset.
// - A sleep request written while in stop mode is ignored.
// - Entering restart sets the mode bits back to normal.
// - Restart entry and overtemperature clear the second regulator bits.
// - Bit 5 switches the third regulator off or on independently.
// - Second regulator: off, normal, normal+stop, always but fail-safe.
// - Overvoltage always flags; bit 2 also requests restart/fail-safe.
// - Bits 1:0 choose one of four main reset thresholds.
// - Serial output during a write shows the old register value.
// - Config bit 7 picks third regulator voltage: main or fixed.
// - Config bit 6 suppresses reset output low during soft reset.
// - Config bit 5 drives failure outputs by software.
// - Clearing bit 5 keeps failure-driven outputs until status clears.
// - Restart entry clears software failure bit and its outputs.
// - Config bit 4 keeps third regulator on at supply undervoltage.
// - Config bit 3 selects load sharing with the main regulator.
// - Config bit 1 allows load sharing during stop mode.
// - Config bit 0 trips on first, not second, watchdog failure.
// - Soft reset keeps config bits marked x in xx00 x00x.
// - Mode register: zero at reset, restart pattern 00x0 00xx.
// - Config register restart pattern xx0x x00x.
// - Config bit 2 is reserved and reads zero.
// - Frame: 7-bit address, access bit 7 (1 write), data byte.
`default_nettype none
module mode_supply_control_regs
    import mode_supply_pkg::*;
#(
    parameter int RESET_LOW_CYCLES = RO_LOW_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial port pins
    input wire logic sclk,
    input wire logic csn,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Global status byte sent first in every frame
    input wire logic [7:0] status_byte,
    // Device state from the mode state machine
    input wire logic in_normal_mode,
    input wire logic in_stop_mode,
    input wire logic in_failsafe_mode,
    input wire logic restart_entry,
    // Monitor events and levels
    input wire logic overtemp_event,
    input wire logic supply_undervoltage,
    input wire logic main_overvoltage_detect,
    input wire logic failure_status,
    // Mode requests toward the state machine
    output logic [1:0] mode_request,
    output logic mode_write_strobe,
    output logic soft_reset_pulse,
    output logic reset_output_pin_low,
    // Regulator controls
    output logic second_regulator_on,
    output logic third_regulator_on,
    output logic third_regulator_voltage_select,
    output logic third_regulator_load_share,
    output logic [1:0] reset_threshold_select,
    // Overvoltage, failure and watchdog controls
    output logic main_overvoltage_flag,
    output logic overvoltage_restart_request,
    output logic failure_outputs,
    output logic watchdog_first_failure_trip
);
    localparam logic [RO_CNT_W-1:0] RO_LOAD =
        RO_CNT_W'(RESET_LOW_CYCLES);

    spi_frame_if frame ();

    logic [7:0] mode_supply_control_reg;
    logic [7:0] mode_supply_control_next;
    logic [7:0] hardware_config_control_reg;
    logic [7:0] hardware_config_control_next;
    logic [RO_CNT_W-1:0] ro_count_reg;
    logic wr_msc, wr_hwc, soft_reset;
    logic [1:0] wr_mode;
    logic [1:0] kept_mode;

    // Read-back of a register by address; unmapped reads give zero
    function automatic logic [7:0] reg_read(
        input logic [6:0] addr,
        input logic [7:0] msc,
        input logic [7:0] hwc
    );
        logic [7:0] value;
        value = 8'h00;
        if (addr == ADDR_MODE_SUPPLY) begin
            value = msc;
        end else if (addr == ADDR_HW_CONFIG) begin
            value = hwc & HWC_WRITE_MASK;
        end
        return value;
    endfunction

    // Pins into the shifter
    assign frame.sclk = sclk;
    assign frame.csn = csn;
    assign frame.sdi = sdi;
    assign frame.status_byte = status_byte;
    assign sdo = frame.sdo;
    assign sdo_oe = frame.sdo_oe;

    // Writes land only at frame end, so this is the old value
    // for the whole frame, including a write to the same address
    assign frame.read_data = reg_read(
        frame.in_addr, mode_supply_control_reg,
        hardware_config_control_reg);

    spi_frame_shifter shifter (
        .clk (clk),
        .srst (srst),
        .bus (frame.shifter)
    );

    // Committed writes, decoded from a complete frame only
    assign wr_msc = frame.frame_done && frame.frame_write
        && frame.frame_addr == ADDR_MODE_SUPPLY;
    assign wr_hwc = frame.frame_done && frame.frame_write
        && frame.frame_addr == ADDR_HW_CONFIG;
    assign wr_mode = frame.frame_data[MODE_HI:MODE_LO];
    assign soft_reset = wr_msc
        && wr_mode == MODE_SOFT_RESET;

    // Stop to sleep is refused; the rest of the write still lands
    always_comb begin
        kept_mode = wr_mode;
        if (in_stop_mode && wr_mode == MODE_SLEEP) begin
            kept_mode = mode_supply_control_reg[MODE_HI:MODE_LO];
        end
    end

    // Next mode/supply value: write first, then hardware changes win
    always_comb begin
        mode_supply_control_next = mode_supply_control_reg;
        if (soft_reset) begin
            mode_supply_control_next = MSC_POR;
        end else if (wr_msc) begin
            mode_supply_control_next = {kept_mode,
                frame.frame_data[THIRD_EN_BIT:THRESH_LO]};
        end
        if (restart_entry) begin
            // Mode returns to normal, second regulator to off
            mode_supply_control_next = mode_supply_control_next
                & MSC_RESTART_KEEP;
        end
        if (overtemp_event) begin
            mode_supply_control_next = mode_supply_control_next
                & SECOND_CLEAR;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_supply_control_reg <= MSC_POR;
        end else begin
            mode_supply_control_reg <= mode_supply_control_next;
        end
    end

    // Next hardware-config value; reserved bit forced to zero
    always_comb begin
        hardware_config_control_next = hardware_config_control_reg;
        if (soft_reset) begin
            hardware_config_control_next = hardware_config_control_reg
                & HWC_SOFT_KEEP;
        end else if (wr_hwc) begin
            // Host writes zero to reserved bits; mask guards anyway
            hardware_config_control_next = frame.frame_data
                & HWC_WRITE_MASK;
        end
        if (restart_entry) begin
            // Also drops the software failure-output request
            hardware_config_control_next = hardware_config_control_next
                & HWC_RESTART_KEEP;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hardware_config_control_reg <= HWC_POR;
        end else begin
            hardware_config_control_reg <= hardware_config_control_next;
        end
    end

    // Mode request toward the state machine
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_request <= MODE_NORMAL;
            mode_write_strobe <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else begin
            mode_request <=
                mode_supply_control_next[MODE_HI:MODE_LO];
            mode_write_strobe <= wr_msc && !soft_reset;
            soft_reset_pulse <= soft_reset;
        end
    end

    // Reset output low window; the old suppress bit decides since
    // the soft reset itself keeps that bit anyway
    always_ff @(posedge clk) begin
        if (srst) begin
            ro_count_reg <= '0;
        end else if (soft_reset
                && !hardware_config_control_reg[RO_SUPPRESS_BIT]) begin
            ro_count_reg <= RO_LOAD;
        end else if (ro_count_reg != '0) begin
            ro_count_reg <= ro_count_reg - RO_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reset_output_pin_low <= 1'b0;
        end else begin
            reset_output_pin_low <= ro_count_reg != '0;
        end
    end

    // Second regulator policy against the present device mode
    always_ff @(posedge clk) begin
        if (srst) begin
            second_regulator_on <= 1'b0;
        end else begin
            unique case (mode_supply_control_reg[SECOND_HI:SECOND_LO])
                2'b00: second_regulator_on <= 1'b0;
                2'b01: second_regulator_on <= in_normal_mode;
                2'b10: second_regulator_on <=
                    in_normal_mode || in_stop_mode;
                2'b11: second_regulator_on <= !in_failsafe_mode;
            endcase
        end
    end

    // Third regulator: enable, undervoltage cut-off, stop-mode
    // load sharing; high-power operation is not seen by this block
    always_ff @(posedge clk) begin
        if (srst) begin
            third_regulator_on <= 1'b0;
            third_regulator_voltage_select <= 1'b0;
            third_regulator_load_share <= 1'b0;
        end else begin
            third_regulator_on <=
                mode_supply_control_reg[THIRD_EN_BIT]
                && (hardware_config_control_reg[KEEP_UV_BIT]
                    || !supply_undervoltage)
                && !(hardware_config_control_reg[LOAD_SHARE_BIT]
                    && in_stop_mode
                    && !hardware_config_control_reg[LS_STOP_BIT]);
            third_regulator_voltage_select <=
                hardware_config_control_reg[VOLT_SEL_BIT];
            third_regulator_load_share <=
                hardware_config_control_reg[LOAD_SHARE_BIT];
        end
    end

    // Threshold and overvoltage reaction
    always_ff @(posedge clk) begin
        if (srst) begin
            reset_threshold_select <= 2'b00;
            main_overvoltage_flag <= 1'b0;
            overvoltage_restart_request <= 1'b0;
        end else begin
            reset_threshold_select <=
                mode_supply_control_reg[THRESH_HI:THRESH_LO];
            main_overvoltage_flag <= main_overvoltage_detect;
            overvoltage_restart_request <= main_overvoltage_detect
                && mode_supply_control_reg[OV_RESTART_BIT];
        end
    end

    // Failure outputs: software request or latched failure status
    always_ff @(posedge clk) begin
        if (srst) begin
            failure_outputs <= 1'b0;
            watchdog_first_failure_trip <= 1'b0;
        end else begin
            failure_outputs <=
                hardware_config_control_next[SW_FAIL_BIT]
                || failure_status;
            watchdog_first_failure_trip <=
                hardware_config_control_reg[WD_COUNT_BIT];
        end
    end
endmodule
`default_nettype wire

// ==== mode_supply_pkg.sv ====
// Constants for the mode and supply control register pair.
// Assumes a 20 MHz clk and a 16-bit LSB-first serial frame.
`default_nettype none
package mode_supply_pkg;
    // Clock rate and serial frame layout
    localparam int CLK_MHZ = 20;
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS = 7;
    localparam int ACCESS_BIT = 7;
    localparam logic [4:0] DATA_START = 5'h08;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] FRAME_OVER = 5'h11;
    // Register addresses
    localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] ADDR_HW_CONFIG = 7'h02;
    // Mode/supply field positions
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int THIRD_EN_BIT = 5;
    localparam int SECOND_HI = 4;
    localparam int SECOND_LO = 3;
    localparam int OV_RESTART_BIT = 2;
    localparam int THRESH_HI = 1;
    localparam int THRESH_LO = 0;
    // Hardware-config field positions
    localparam int VOLT_SEL_BIT = 7;
    localparam int RO_SUPPRESS_BIT = 6;
    localparam int SW_FAIL_BIT = 5;
    localparam int KEEP_UV_BIT = 4;
    localparam int LOAD_SHARE_BIT = 3;
    localparam int LS_STOP_BIT = 1;
    localparam int WD_COUNT_BIT = 0;
    // Values after reset and keep masks (1 = bit unchanged)
    localparam logic [7:0] MSC_POR = 8'h00;
    localparam logic [7:0] MSC_RESTART_KEEP = 8'h23;
    localparam logic [7:0] HWC_POR = 8'h00;
    localparam logic [7:0] HWC_SOFT_KEEP = 8'hc9;
    localparam logic [7:0] HWC_RESTART_KEEP = 8'hd9;
    localparam logic [7:0] HWC_WRITE_MASK = 8'hfb;
    localparam logic [7:0] SECOND_CLEAR = 8'he7;
    // Reset output low time during a soft reset
    localparam int RO_LOW_US = 10;
    localparam int RO_LOW_CYCLES = RO_LOW_US * CLK_MHZ;
    localparam int RO_CNT_W = 8;
    // Operating mode codes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_STOP = 2'b10,
        MODE_SOFT_RESET = 2'b11
    } mode_code_t;
endpackage
`default_nettype wire

// ==== spi_frame_if.sv ====
// Carrier between the register file and its serial shifter.
// Pins are sampled on clk; frame_done is a one-cycle pulse.
`default_nettype none
interface spi_frame_if;
    logic sclk;
    logic csn;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic [7:0] status_byte;
    logic [7:0] read_data;
    logic [6:0] frame_addr, in_addr;
    logic frame_write;
    logic [7:0] frame_data;
    logic frame_done;
    modport shifter (
        input sclk, csn, sdi, status_byte, read_data,
        output sdo, sdo_oe, frame_addr, frame_write, frame_data,
        output frame_done, in_addr
    );
    modport regs (
        output sclk, csn, sdi, status_byte, read_data,
        input sdo, sdo_oe, frame_addr, frame_write, frame_data,
        input frame_done, in_addr
    );
endinterface
`default_nettype wire

// ==== spi_frame_shifter.sv ====
// Serial shifter: sdi taken on falling sclk, sdo moved on rising.
// Assumes sclk, csn and sdi are already synchronous to clk.
`default_nettype none
module spi_frame_shifter
    import mode_supply_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register side
    spi_frame_if.shifter bus
);
    logic sclk_prev;
    logic csn_prev;
    logic [FRAME_BITS-1:0] in_reg;
    logic [4:0] count_reg;
    logic [7:0] out_reg;
    logic sclk_rise, sclk_fall, csn_fall, csn_rise;

    // Edge detection on the sampled pins
    assign sclk_rise = bus.sclk && !sclk_prev && !bus.csn;
    assign sclk_fall = !bus.sclk && sclk_prev && !bus.csn;
    assign csn_fall = !bus.csn && csn_prev;
    assign csn_rise = bus.csn && !csn_prev;

    always_ff @(posedge clk) begin
        if (srst) begin
            sclk_prev <= 1'b0;
            csn_prev <= 1'b1;
        end else begin
            sclk_prev <= bus.sclk;
            csn_prev <= bus.csn;
        end
    end

    // Input shift, LSB first; bit count saturates past a full frame
    always_ff @(posedge clk) begin
        if (srst) begin
            in_reg <= '0;
            count_reg <= 5'h00;
        end else if (csn_fall) begin
            count_reg <= 5'h00;
        end else if (sclk_fall && count_reg != FRAME_OVER) begin
            in_reg <= {bus.sdi, in_reg[FRAME_BITS-1:1]};
            count_reg <= count_reg + 5'h01;
        end
    end

    // Output byte: status first, then the addressed register
    always_ff @(posedge clk) begin
        if (srst) begin
            out_reg <= 8'h00;
            bus.sdo <= 1'b0;
        end else if (csn_fall) begin
            out_reg <= bus.status_byte;
            bus.sdo <= bus.status_byte[0];
        end else if (sclk_fall && count_reg == DATA_START - 5'h01) begin
            out_reg <= bus.read_data;
        end else if (sclk_rise && count_reg != 5'h00
                && count_reg < FRAME_LEN) begin
            bus.sdo <= out_reg[count_reg[2:0]];
        end
    end

    // Frame fields, held until the next full frame ends; frame_done one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            bus.frame_done <= 1'b0;
            bus.frame_addr <= 7'h00;
            bus.frame_write <= 1'b0;
            bus.frame_data <= 8'h00;
            bus.sdo_oe <= 1'b0;
        end else begin
            bus.sdo_oe <= !bus.csn;
            bus.frame_done <= csn_rise && count_reg == FRAME_LEN;
            if (csn_rise && count_reg == FRAME_LEN) begin
                bus.frame_addr <= in_reg[ADDR_BITS-1:0];
                bus.frame_write <= in_reg[ACCESS_BIT];
                bus.frame_data <= in_reg[FRAME_BITS-1:8];
            end
        end
    end

    // Address in flight, whole after seven bits
    assign bus.in_addr = in_reg[FRAME_BITS-1:9];
endmodule
`default_nettype wire

// ==== mode_supply_props.sv ====
// Port checker for the mode/supply control register block.
// Bound to the block; one clock domain, synchronous reset.
`default_nettype none
module mode_supply_props
    import mode_supply_pkg::*;
#(
    parameter int RESET_LOW_CYCLES = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched ports
    input wire logic csn,
    input wire logic sdo_oe,
    input wire logic restart_entry,
    input wire logic main_overvoltage_detect,
    input wire logic failure_status,
    input wire logic [1:0] mode_request,
    input wire logic mode_write_strobe,
    input wire logic soft_reset_pulse,
    input wire logic reset_output_pin_low,
    input wire logic second_regulator_on,
    input wire logic main_overvoltage_flag,
    input wire logic overvoltage_restart_request,
    input wire logic failure_outputs
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    int lo_cnt;
    // Length of the reset-low stretch, bounded by the parameter
    always_ff @(posedge clk) begin
        lo_cnt <= reset_output_pin_low ? lo_cnt + 1 : 0;
    end
    property p_ov_flag;
        !$past(srst) |-> main_overvoltage_flag == $past(main_overvoltage_detect);
    endproperty
    a_ov_flag: assert property (p_ov_flag) else $error("ov flag");
    property p_ov_req;
        overvoltage_restart_request |->
            main_overvoltage_detect || $past(main_overvoltage_detect);
    endproperty
    a_ov_req: assert property (p_ov_req) else $error("ov req");
    property p_oe;
        !$past(srst) |-> sdo_oe == !$past(csn);
    endproperty
    a_oe: assert property (p_oe) else $error("sdo enable");
    property p_restart;
        restart_entry |-> ##[1:3] (mode_request == MODE_NORMAL
            && !second_regulator_on);
    endproperty
    a_restart: assert property (p_restart) else $error("restart");
    property p_fo_clear;
        restart_entry && !failure_status |-> ##[1:3] !failure_outputs;
    endproperty
    a_fo_clear: assert property (p_fo_clear) else $error("fo clr");
    property p_fo_hold;
        failure_status [*2] |-> failure_outputs;
    endproperty
    a_fo_hold: assert property (p_fo_hold) else $error("fo hold");
    property p_soft;
        soft_reset_pulse |=> !soft_reset_pulse;
    endproperty
    a_soft: assert property (p_soft) else $error("soft pulse");
    property p_strobe;
        mode_write_strobe |-> ($past(csn) || $past(csn, 2))
            ##1 !mode_write_strobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe");
    property p_ro_len;
        lo_cnt <= RESET_LOW_CYCLES + 1;
    endproperty
    a_ro_len: assert property (p_ro_len) else $error("ro length");
    property p_ro_cause;
        $rose(reset_output_pin_low) |-> $past(soft_reset_pulse)
            || $past(soft_reset_pulse, 2) || $past(soft_reset_pulse, 3);
    endproperty
    a_ro_cause: assert property (p_ro_cause) else $error("ro cause");
    // Main scenarios reached
    c_soft: cover property (soft_reset_pulse);
    c_restart: cover property (restart_entry);
    c_ro: cover property ($rose(reset_output_pin_low));
endmodule
bind mode_supply_control_regs mode_supply_props #(
    .RESET_LOW_CYCLES(RESET_LOW_CYCLES)
) props (.clk, .srst, .csn, .sdo_oe, .restart_entry,
    .main_overvoltage_detect, .failure_status, .mode_request,
    .mode_write_strobe, .soft_reset_pulse, .reset_output_pin_low,
    .second_regulator_on, .main_overvoltage_flag,
    .overvoltage_restart_request, .failure_outputs);
`default_nettype wire

// ==== spi_host_model.sv ====
// Host controller model driving 16-bit LSB-first serial frames.
// Assumes the device samples pins on clk; sclk idles low.
`default_nettype none
module spi_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic sclk,
    output logic csn,
    output logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b0;
        csn = 1'b1;
        sdi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Address, access bit, then data byte, LSB first
    task automatic xfer(input logic [15:0] tx, input int nbits,
                        output logic [15:0] rx);
        rx = 16'h0000;
        csn = 1'b0;
        tick(3);
        for (int i = 0; i < nbits; i++) begin
            sdi = tx[i];
            sclk = 1'b1;
            tick(3);
            rx[i] = sdo;
            sclk = 1'b0;
            tick(3);
        end
        csn = 1'b1;
        sdi = ~sdi; // Released line shows no stale bit
        tick(3);
    endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the mode/supply control registers.
// Serial traffic comes from the host model; state inputs driven here.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import mode_supply_pkg::*;
    localparam int LOWC = 4;
    localparam logic [6:0] MSC = ADDR_MODE_SUPPLY;
    localparam logic [6:0] HWC = ADDR_HW_CONFIG;
    logic clk = 1'b0, srst = 1'b1;
    logic sclk, csn, sdi, sdo;
    logic nrm = 1'b1, stp = 1'b0, fsf = 1'b0, rse = 1'b0, ot = 1'b0;
    logic uv = 1'b0, ovd = 1'b0, fst = 1'b0;
    logic [1:0] mreq, thr;
    logic mstb, srp, rlo, v2, v3, v3sel, v3ls, ovf, ovr, fo, wdt;
    int fails = 0, cmp_count = 0, sr_cnt = 0, ro_cnt = 0, mw_cnt = 0;
    // 50 ns clock
    always #25 clk = ~clk;
    spi_host_model host (.clk, .sclk, .csn, .sdi, .sdo);
    mode_supply_control_regs #(.RESET_LOW_CYCLES(LOWC)) dut (
        .clk, .srst, .sclk, .csn, .sdi, .sdo, .sdo_oe(),
        .status_byte(8'ha5), .in_normal_mode(nrm), .in_stop_mode(stp),
        .in_failsafe_mode(fsf), .restart_entry(rse), .overtemp_event(ot),
        .supply_undervoltage(uv), .main_overvoltage_detect(ovd),
        .failure_status(fst), .mode_request(mreq), .mode_write_strobe(mstb),
        .soft_reset_pulse(srp), .reset_output_pin_low(rlo),
        .second_regulator_on(v2), .third_regulator_on(v3),
        .third_regulator_voltage_select(v3sel),
        .third_regulator_load_share(v3ls), .reset_threshold_select(thr),
        .main_overvoltage_flag(ovf), .overvoltage_restart_request(ovr),
        .failure_outputs(fo), .watchdog_first_failure_trip(wdt));
    // Pulse counters, one-cycle srp and mstb seen in their cycle; rlo counted per low cycle
    always @(posedge clk) begin
        if (srp === 1'b1) sr_cnt++;
        if (rlo === 1'b1) ro_cnt++;
        if (mstb === 1'b1) mw_cnt++;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t %s: got %h exp %h", $time, what, seen, exp);
        end
    endtask
    // Register access; commit lands two clocks after csn rises
    task automatic wr(input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] old);
        logic [15:0] rx;
        host.xfer({d, 1'b1, a}, 16, rx);
        old = rx[15:8];
        step(6);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        logic [15:0] rx;
        host.xfer({8'h00, 1'b0, a}, 16, rx);
        v = rx[15:8];
        chk(rx[7:0], 8'ha5, "status byte");
    endtask
    task automatic state(input int s);
        nrm = (s == 0);
        stp = (s == 1);
        fsf = (s == 2);
        step(3);
    endtask
    function automatic logic exp2(input logic [1:0] p, input int s);
        return p == 2'h3 ? s != 2 : p == 2'h2 ? s < 2 : p == 2'h1 && s == 0;
    endfunction
    task automatic t_reset;
        logic [7:0] v;
        rd(MSC, v);
        chk(v, MSC_POR, "msc reset");
        rd(HWC, v);
        chk(v, HWC_POR, "hwc reset");
        chk(8'({v2, v3, fo, wdt}), 8'h00, "reset outputs");
        $display("test reset done");
    endtask
    task automatic t_fields;
        logic [7:0] v, old;
        logic [1:0] p;
        old = 8'h00;
        for (int i = 0; i < 4; i++) begin
            p = 2'(i);
            state(0);
            wr(MSC, {3'b001, p, 1'b0, p}, v);
            chk(v, old, "old value on write");
            old = {3'b001, p, 1'b0, p};
            chk(8'(thr), 8'(p), "threshold");
            chk(8'(v3), 8'h01, "third on");
            for (int s = 0; s < 4; s++) begin
                state(s);
                chk(8'(v2), 8'(exp2(p, s)), "second reg");
            end
        end
        state(0);
        chk(8'(mw_cnt), 8'h04, "mode strobes");
        $display("test fields done");
    endtask
    task automatic t_hwc;
        logic [7:0] v;
        wr(HWC, 8'hfb, v); // Reserved bit left zero
        rd(HWC, v);
        chk(v, 8'hfb, "reserved reads 0");
        uv = 1'b1;
        step(3);
        chk(8'({v3sel, v3ls, wdt, fo, v3}), 8'h1f, "hwc set");
        wr(HWC, 8'h08, v);
        chk(8'({v3sel, v3ls, wdt, fo, v3}), 8'h08, "hwc cleared");
        uv = 1'b0;
        state(1);
        chk(8'(v3), 8'h00, "ls in stop off");
        wr(HWC, 8'h0a, v);
        chk(8'(v3), 8'h01, "ls in stop on");
        state(0);
        fst = 1'b1;
        wr(HWC, 8'h20, v);
        wr(HWC, 8'h00, v);
        chk(8'(fo), 8'h01, "fo held by failure");
        fst = 1'b0;
        step(3);
        chk(8'(fo), 8'h00, "fo released");
        $display("test hwc done");
    endtask
    task automatic t_frames;
        logic [15:0] rx;
        logic [7:0] v;
        host.xfer({8'hc0, 1'b1, MSC}, 15, rx);
        wr(7'h05, 8'h5a, v);
        rd(MSC, v);
        chk(v, 8'h3b, "short frame ignored");
        rd(7'h05, v);
        chk(v, 8'h00, "unmapped reads 0");
        state(1);
        wr(MSC, 8'h80, v);
        wr(MSC, 8'h40, v);
        rd(MSC, v);
        chk(v, 8'h80, "no stop to sleep");
        chk(8'(mreq), 8'(MODE_STOP), "mode stays stop");
        state(0);
        wr(MSC, 8'h04, v);
        ovd = 1'b1;
        step(3);
        chk(8'({ovf, ovr}), 8'h03, "ov restart on");
        wr(MSC, 8'h00, v);
        chk(8'({ovf, ovr}), 8'h02, "ov flag only");
        ovd = 1'b0;
        $display("test frames done");
    endtask
    task automatic t_restart;
        logic [7:0] v;
        wr(MSC, 8'h7f, v);
        wr(HWC, 8'hfb, v);
        rse = 1'b1;
        step(1);
        rse = 1'b0;
        step(4);
        chk(8'({mreq, fo}), 8'h00, "restart outputs");
        rd(MSC, v);
        chk(v, 8'h23, "msc restart");
        rd(HWC, v);
        chk(v, 8'hd9, "hwc restart");
        wr(MSC, 8'h18, v);
        ot = 1'b1;
        step(1);
        ot = 1'b0;
        rd(MSC, v);
        chk(v, 8'h00, "overtemp clears");
        $display("test restart done");
    endtask
    task automatic t_soft;
        logic [7:0] v;
        wr(MSC, 8'hc0, v);
        chk(8'({sr_cnt[6:0], ro_cnt != 0}), 8'h02, "soft no ro");
        rd(MSC, v);
        chk(v, MSC_POR, "msc soft");
        rd(HWC, v);
        chk(v, 8'hc9, "hwc soft");
        wr(HWC, 8'h89, v);
        wr(MSC, 8'hc0, v);
        chk(8'({sr_cnt[6:0], ro_cnt != 0}), 8'h05, "soft with ro");
        rd(HWC, v);
        chk(v, 8'h89, "hwc kept");
        $display("test soft done");
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence; reset held four clocks
    initial begin
        step(4);
        srst = 1'b0;
        step(1);
        t_reset;
        t_fields;
        t_hwc;
        t_frames;
        t_restart;
        t_soft;
        give_verdict;
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        give_verdict;
    end
endmodule
`default_nettype wire
